// File: hdl/cssr_regs.sv
// Processor special status registers: exception number, execution state, priority mask, control.
//
// Functional notes
// - Exception number in bits 5:0.
// - Codes: thread, hard fault, call, lines.
// - Execution state flag at bit 24.
// - Software read of execution state gives zero.
// - Software write of execution state ignored.
// - Stacked status word carries true flag.
// - Interrupt abandons multi-register transfer.
// - Abandoned transfer restarts from first transfer.
// - Execution only with flag set.
// - Flag cleared by branch, return, vector.
// - Executing with flag clear faults or locks.
// - Priority mask bit 0 blocks configurable exceptions.
// - Mask changed by move or state change.
// - Control bit 1 selects process stack.
// - Handler mode: select reads zero, ignores writes.
// - Handler mode always uses main stack.
// - Entry and return update control automatically.
// - Control is zero after reset.
// - After barrier new stack is used.
// - Every exception but reset enters handler, unless in lockup or faulting in handler.
// - Status word write keeps exception number.
`timescale 1ns/100ps
`default_nettype none
`include "cssr_cfg.svh"
module cssr_regs
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [2:0]  sreg_sel,
	input  wire logic        sreg_wr,
	input  wire logic [31:0] sreg_wdata,
	output logic [31:0]      sreg_rdata,
	input  wire logic        cps_set,
	input  wire logic        cps_clear,
	input  wire logic        exc_entry,
	input  wire logic [5:0]  exc_entry_num,
	input  wire logic [31:0] exc_vector,
	input  wire logic        exc_return,
	input  wire logic [5:0]  exc_return_num,
	input  wire logic [31:0] exc_return_psw,
	input  wire logic        exc_return_stksel,
	input  wire logic        branch_exchange,
	input  wire logic [31:0] branch_target,
	input  wire logic        instruction_sync_barrier,
	input  wire logic        instr_issue,
	input  wire logic        multi_xfer_busy,
	input  wire logic [31:0] multi_xfer_addr,
	input  wire logic        cfg_exc_request,
	output logic             cfg_exc_allowed,
	output logic             exec_allowed,
	output logic             exec_fault,
	output logic             lockup,
	output logic             handler_mode,
	output logic             use_process_stack,
	output logic [31:0]      stacked_psw,
	output logic             multi_abandon,
	output logic             multi_restart,
	output logic [31:0]      restart_addr
);
	// ****************************************************************
	// State
	// ****************************************************************
	cssr_pkg::cssr_state_t state_r;
	logic [5:0]            exc_num_r;
	logic                  exs_flag_r;
	logic                  configurable_priority_mask_r;
	logic                  stksel_r;
	logic                  active_stk_r;
	logic                  fault_now;
	logic                  wr_control;
	logic                  wr_configurable_priority_mask;

	assign handler_mode = (state_r == cssr_pkg::CSSR_ST_HANDLER);
	assign wr_control   = sreg_wr & (sreg_sel == `CSSR_SEL_CONTROL);
	assign wr_configurable_priority_mask   = sreg_wr & (sreg_sel == `CSSR_SEL_CONFIGURABLE_PRIORITY_MASK);
	assign exec_allowed = exs_flag_r & (state_r != cssr_pkg::CSSR_ST_LOCKUP);
	assign fault_now    = instr_issue & ~exs_flag_r;
	assign exec_fault   = fault_now;
	assign lockup       = (state_r == cssr_pkg::CSSR_ST_LOCKUP);
	assign cfg_exc_allowed = cfg_exc_request & ~configurable_priority_mask_r;
	assign use_process_stack = active_stk_r;

	// ****************************************************************
	// Mode
	// ****************************************************************
	// A fault inside the handler cannot be serviced again and locks the core.
	always_ff @(posedge clk)
	begin
		if (rst)
			state_r <= cssr_pkg::CSSR_ST_THREAD;
		else
		begin
			case (state_r)
				cssr_pkg::CSSR_ST_THREAD:
					if (exc_entry | fault_now)
						state_r <= cssr_pkg::CSSR_ST_HANDLER;
				cssr_pkg::CSSR_ST_HANDLER:
					if (fault_now)
						state_r <= cssr_pkg::CSSR_ST_LOCKUP;
					else if (exc_return && exc_return_num == `CSSR_EXC_THREAD)
						state_r <= cssr_pkg::CSSR_ST_THREAD;
				cssr_pkg::CSSR_ST_LOCKUP:
					state_r <= cssr_pkg::CSSR_ST_LOCKUP;
				default:
					state_r <= cssr_pkg::CSSR_ST_THREAD;
			endcase
		end
	end

	// ****************************************************************
	// Exception number
	// ****************************************************************
	// Status word writes never reach this field.
	always_ff @(posedge clk)
	begin
		if (rst)
			exc_num_r <= `CSSR_EXC_RESET;
		else if (fault_now && state_r == cssr_pkg::CSSR_ST_THREAD)
			exc_num_r <= `CSSR_EXC_HARD_FAULT;
		else if (exc_entry)
			exc_num_r <= exc_entry_num;
		else if (exc_return)
			exc_num_r <= exc_return_num;
	end

	// ****************************************************************
	// Execution state flag
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
			exs_flag_r <= `CSSR_FLAG_RESET;
		else if (exc_entry)
			exs_flag_r <= exc_vector[0];
		else if (exc_return)
			exs_flag_r <= exc_return_psw[`CSSR_EXS_FLAG_BIT];
		else if (branch_exchange)
			exs_flag_r <= branch_target[0];
	end

	// ****************************************************************
	// Priority mask
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
			configurable_priority_mask_r <= `CSSR_CONFIGURABLE_PRIORITY_MASK_RESET;
		else if (cps_set)
			configurable_priority_mask_r <= 1'b1;
		else if (cps_clear)
			configurable_priority_mask_r <= 1'b0;
		else if (wr_configurable_priority_mask)
			configurable_priority_mask_r <= sreg_wdata[`CSSR_CONFIGURABLE_PRIORITY_MASK_BIT];
	end

	// ****************************************************************
	// Stack control
	// ****************************************************************
	// Entry forces the main stack; return restores the thread choice.
	always_ff @(posedge clk)
	begin
		if (rst)
			stksel_r <= 1'(`CSSR_CONTROL_RESET >> `CSSR_STKSEL_BIT);
		else if (exc_entry)
			stksel_r <= 1'b0;
		else if (exc_return)
			stksel_r <= exc_return_stksel;
		else if (wr_control && !handler_mode)
			stksel_r <= sreg_wdata[`CSSR_STKSEL_BIT];
	end

	// The pointer in use follows the select bit only at a barrier or mode change.
	always_ff @(posedge clk)
	begin
		if (rst)
			active_stk_r <= 1'b0;
		else if (exc_entry || fault_now)
			active_stk_r <= 1'b0;
		else if (exc_return)
			active_stk_r <= exc_return_stksel & (exc_return_num == `CSSR_EXC_THREAD);
		else if (handler_mode)
			active_stk_r <= 1'b0;
		else if (instruction_sync_barrier)
			active_stk_r <= stksel_r;
	end

	// ****************************************************************
	// Stacked status word
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
			stacked_psw <= 32'h00000000;
		else if (exc_entry)
		begin
			stacked_psw <= 32'h00000000;
			stacked_psw[`CSSR_EXS_FLAG_BIT] <= exs_flag_r;
			stacked_psw[`CSSR_EXC_NUM_W-1:0] <= exc_num_r;
		end
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
			sreg_rdata <= 32'h00000000;
		else
		begin
			sreg_rdata <= 32'h00000000;
			case (sreg_sel)
				`CSSR_SEL_EXC_NUM:
					sreg_rdata[`CSSR_EXC_NUM_W-1:0] <= exc_num_r;
				`CSSR_SEL_EXEC_STATE:
					sreg_rdata <= 32'h00000000;
				`CSSR_SEL_CONFIGURABLE_PRIORITY_MASK:
					sreg_rdata[`CSSR_CONFIGURABLE_PRIORITY_MASK_BIT] <= configurable_priority_mask_r;
				`CSSR_SEL_CONTROL:
					sreg_rdata[`CSSR_STKSEL_BIT] <= stksel_r & ~handler_mode;
				`CSSR_SEL_PSW:
					sreg_rdata[`CSSR_EXC_NUM_W-1:0] <= exc_num_r;
				default:
					sreg_rdata <= 32'h00000000;
			endcase
		end
	end

	// ****************************************************************
	// Multi-register transfer restart
	// ****************************************************************
	cssr_restart u_restart
	(
		.clk             (clk),
		.rst             (rst),
		.multi_xfer_busy (multi_xfer_busy),
		.exc_entry       (exc_entry),
		.exc_return      (exc_return),
		.multi_xfer_addr (multi_xfer_addr),
		.multi_abandon   (multi_abandon),
		.multi_restart   (multi_restart),
		.restart_addr    (restart_addr)
	);
endmodule // cssr_regs
`default_nettype wire

// File: hdl/cssr_cfg.svh
// Constants for the processor special status register block.
`ifndef CSSR_CFG_SVH
`define CSSR_CFG_SVH
`define CSSR_EXC_NUM_LSB      0
`define CSSR_EXC_NUM_W        6
`define CSSR_EXC_THREAD       6'h00
`define CSSR_EXC_HARD_FAULT   6'h03
`define CSSR_EXC_SUPERVISOR_CALL_EXCEPTION       6'h0B
`define CSSR_EXC_IRQ_BASE     6'h10
`define CSSR_EXC_IRQ_LAST     6'h2F
`define CSSR_EXS_FLAG_BIT     24
`define CSSR_CONFIGURABLE_PRIORITY_MASK_BIT      0
`define CSSR_STKSEL_BIT       1
`define CSSR_EXC_RESET        6'h00
`define CSSR_FLAG_RESET       1'b1
`define CSSR_CONFIGURABLE_PRIORITY_MASK_RESET    1'b0
`define CSSR_CONTROL_RESET    32'h00000000
`define CSSR_SEL_EXC_NUM      3'h0
`define CSSR_SEL_EXEC_STATE   3'h1
`define CSSR_SEL_CONFIGURABLE_PRIORITY_MASK      3'h2
`define CSSR_SEL_CONTROL      3'h3
`define CSSR_SEL_PSW          3'h4
`endif

// File: hdl/cssr_pkg.sv
// Types for the processor special status register block.
package cssr_pkg;
	typedef enum logic [1:0]
	{
		CSSR_ST_THREAD  = 2'b00,
		CSSR_ST_HANDLER = 2'b01,
		CSSR_ST_LOCKUP  = 2'b10
	} cssr_state_t;
endpackage

// File: hdl/cssr_restart.sv
// Tracks the abandon-and-restart of multi-register transfers.
`timescale 1ns/100ps
`default_nettype none
module cssr_restart
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        multi_xfer_busy,
	input  wire logic        exc_entry,
	input  wire logic        exc_return,
	input  wire logic [31:0] multi_xfer_addr,
	output logic             multi_abandon,
	output logic             multi_restart,
	output logic [31:0]      restart_addr
);
	logic pending_r;

	// Abandon is combinational so the transfer stops in the entry cycle.
	assign multi_abandon = exc_entry & multi_xfer_busy;

	always_ff @(posedge clk)
	begin
		if (rst)
			pending_r <= 1'b0;
		else if (multi_abandon)
			pending_r <= 1'b1;
		else if (exc_return)
			pending_r <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			restart_addr <= 32'h00000000;
		else if (multi_abandon)
			restart_addr <= multi_xfer_addr;
	end

	// The instruction is rerun from its first transfer on return.
	always_ff @(posedge clk)
	begin
		if (rst)
			multi_restart <= 1'b0;
		else
			multi_restart <= exc_return & pending_r;
	end
endmodule // cssr_restart
`default_nettype wire

// File: verif/cssr_props.sv
// Concurrent checks on the ports of the special status register block.
`timescale 1ns/100ps
`default_nettype none
`include "cssr_cfg.svh"
module cssr_props
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [2:0]  sreg_sel,
	input wire logic [31:0] sreg_rdata,
	input wire logic        cps_set,
	input wire logic        cps_clear,
	input wire logic        cfg_exc_request,
	input wire logic        cfg_exc_allowed,
	input wire logic        exc_entry,
	input wire logic        multi_xfer_busy,
	input wire logic        multi_abandon,
	input wire logic        instr_issue,
	input wire logic        exec_allowed,
	input wire logic        exec_fault,
	input wire logic        handler_mode,
	input wire logic        use_process_stack
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	mask_block_a: assert property (cps_set |=> !cfg_exc_allowed)
		else $error("Mask set left request allowed.");
	mask_clear_a: assert property (cps_clear && !cps_set |=> cfg_exc_allowed == cfg_exc_request)
		else $error("Mask clear did not pass request.");
	xfer_abandon_a: assert property (multi_abandon == (exc_entry && multi_xfer_busy))
		else $error("Abandon does not follow entry during transfer.");
	exs_zero_a: assert property (sreg_sel == `CSSR_SEL_EXEC_STATE |=> sreg_rdata == 32'h0)
		else $error("Execution state read not zero.");
	excnum_rsvd_a: assert property (sreg_sel == `CSSR_SEL_EXC_NUM |=> sreg_rdata[31:6] == 26'h0)
		else $error("Exception number upper bits not zero.");
	hctrl_zero_a: assert property (handler_mode && sreg_sel == `CSSR_SEL_CONTROL |=> sreg_rdata == 32'h0)
		else $error("Control read not zero in handler.");
	hstack_main_a: assert property (handler_mode |-> !use_process_stack)
		else $error("Process stack used in handler.");
	entry_hmode_a: assert property (exc_entry |=> handler_mode)
		else $error("Entry did not reach handler.");
	exec_ok_a: assert property (instr_issue && exec_allowed |-> !exec_fault)
		else $error("Fault while execution allowed.");
	abandon_c: cover property (exc_entry && multi_xfer_busy);
	fault_c: cover property (exec_fault);
	hctrl_c: cover property (handler_mode && sreg_sel == `CSSR_SEL_CONTROL);
endmodule // cssr_props
bind cssr_regs cssr_props u_props (.*);
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the special status register block.
`timescale 1ns/100ps
`default_nettype none
`include "cssr_cfg.svh"
module tb_top;
	logic clk = 0, rst = 1, sreg_wr = 0, cps_set = 0, cps_clear = 0, exc_entry = 0, exc_return = 0;
	logic exc_return_stksel = 0, branch_exchange = 0, instruction_sync_barrier = 0, instr_issue = 0, multi_xfer_busy = 0;
	logic cfg_exc_request = 1, rd_v = 0;
	logic [2:0] sreg_sel = 3'h0;
	logic [5:0] exc_entry_num = 6'h00, exc_return_num = 6'h00;
	logic [31:0] sreg_wdata = 32'h0, exc_vector = 32'h1, exc_return_psw = 32'h01000000;
	logic [31:0] branch_target = 32'h1, multi_xfer_addr = 32'h0, w, q[$];
	logic [31:0] sreg_rdata, stacked_psw, restart_addr;
	logic cfg_exc_allowed, exec_allowed, exec_fault, lockup, handler_mode, use_process_stack;
	logic multi_abandon, multi_restart;
	logic [5:0] codes [4] = '{6'h03, 6'h0B, 6'h10, 6'h2F};
	int n_fail = 0, cmp_count = 0, cyc = 0;
	cssr_regs dut (.*);
	always #12.5 clk = ~clk;
	task step;
		@(posedge clk);
		#1;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task rd(input logic [2:0] s, input logic [31:0] e);
		sreg_sel = s;
		rd_v = 1;
		q.push_back(e);
		step;
		rd_v = 0;
		step;
	endtask
	task wr(input logic [2:0] s, input logic [31:0] d);
		sreg_sel = s;
		sreg_wr = 1;
		sreg_wdata = d;
		step;
		sreg_wr = 0;
		step;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step;
		s = 0;
		step;
	endtask
	task print_verdict;
		$display("Compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ****************************************
	// Read results are compared in request order.
	// ****************************************
	always @(posedge clk)
		if (rd_v)
		begin
			#2;
			chk(sreg_rdata, q.pop_front());
		end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			n_fail++;
			print_verdict;
		end
	end
	initial
	begin
		w = $urandom(32'h090CCD52);
		repeat (5) @(posedge clk);
		#1;
		rst = 0;
		rd(`CSSR_SEL_EXC_NUM, 32'h0);
		rd(`CSSR_SEL_CONTROL, 32'h0);
		chk(exec_allowed, 32'h1);
		$display("Reset test done");
		w = $urandom;
		wr(`CSSR_SEL_CONFIGURABLE_PRIORITY_MASK, w);
		rd(`CSSR_SEL_CONFIGURABLE_PRIORITY_MASK, {31'h0, w[0]});
		pulse(cps_set);
		chk(cfg_exc_allowed, 32'h0);
		rd(`CSSR_SEL_CONFIGURABLE_PRIORITY_MASK, 32'h1);
		pulse(cps_clear);
		chk(cfg_exc_allowed, 32'h1);
		wr(`CSSR_SEL_EXEC_STATE, 32'hFFFFFFFF);
		rd(`CSSR_SEL_EXEC_STATE, 32'h0);
		wr(`CSSR_SEL_CONTROL, w | 32'h2);
		rd(`CSSR_SEL_CONTROL, 32'h2);
		pulse(instruction_sync_barrier);
		chk(use_process_stack, 32'h1);
		$display("Mask and control test done");
		foreach (codes[i])
		begin
			exc_entry = 1;
			exc_entry_num = codes[i];
			multi_xfer_busy = w[i];
			multi_xfer_addr = w;
			#1;
			chk(multi_abandon, w[i]);
			step;
			exc_entry = 0;
			multi_xfer_busy = 0;
			chk(handler_mode, 32'h1);
			chk(stacked_psw[24], 32'h1);
			chk(stacked_psw[5:0], 32'h0);
			rd(`CSSR_SEL_EXC_NUM, codes[i]);
			chk(use_process_stack, 32'h0);
			wr(`CSSR_SEL_CONTROL, 32'h2);
			rd(`CSSR_SEL_CONTROL, 32'h0);
			wr(`CSSR_SEL_PSW, $urandom);
			rd(`CSSR_SEL_EXC_NUM, codes[i]);
			exc_return = 1;
			exc_return_stksel = w[i + 4];
			step;
			exc_return = 0;
			chk(multi_restart, w[i]);
			if (w[i])
				chk(restart_addr, w);
			chk(handler_mode, 32'h0);
			chk(use_process_stack, w[i + 4]);
			rd(`CSSR_SEL_CONTROL, {30'h0, w[i + 4], 1'b0});
		end
		$display("Exception test done");
		branch_target = 32'hFFFFFFFE;
		pulse(branch_exchange);
		chk(exec_allowed, 32'h0);
		instr_issue = 1;
		#1;
		chk(exec_fault, 32'h1);
		step;
		instr_issue = 0;
		chk(use_process_stack, 32'h0);
		rd(`CSSR_SEL_EXC_NUM, 32'h3);
		pulse(instr_issue);
		chk(lockup, 32'h1);
		rst = 1;
		step;
		rst = 0;
		rd(`CSSR_SEL_CONTROL, 32'h0);
		chk(exec_allowed, 32'h1);
		$display("Fault test done");
		print_verdict;
	end
endmodule // tb_top
`default_nettype wire
